// file: design/acp_ctrl.sv
// Purpose: power mode and conversion sequencing of a 10-bit converter
// Assumes: convert_start_n and link signals are asynchronous to sys_clk
// Notes: the analog converter is outside; we drive its enables
`timescale 1ns/10ps
module acp_ctrl #(
  parameter int PWRUP_CYC = acp_pkg::PWRUP_CYC,
  parameter int CONV_CYC = acp_pkg::CONV_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic convert_start_n,
  input wire logic read_frame_sync,
  input wire logic write_frame_sync,
  input wire logic data_in,
  input wire logic [9:0] sar_result,
  output logic data_out,
  output logic data_out_en,
  output logic power_field_high,
  output logic power_field_low,
  output logic analog_on,
  output logic ref_on,
  output logic tracking,
  output logic converting,
  output logic ext_ref,
  output logic result_ready
);
  logic [2:0] cs_q;
  logic [2:0] ctgl_q;
  logic [1:0] rbusy_q;
  logic [15:0] ctrl_q;
  logic [15:0] result_q;
  logic [15:0] pend_q;
  logic pend_valid_q;
  logic [15:0] cw_link;
  logic ctgl_link;
  logic rbusy_link;
  logic [1:0] pf;
  logic cs_fall;
  logic cs_rise;
  logic start_pend_q;
  logic [15:0] cnt_q;
  acp_pkg::acp_state_t st_q;
  acp_pkg::acp_pwr_t pwr;

  // ----------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------
  acp_serial u_ser (
    .link_clk(link_clk),
    .resetn(resetn),
    .read_frame_sync(read_frame_sync),
    .write_frame_sync(write_frame_sync),
    .data_in(data_in),
    .result_word(result_q),
    .data_out(data_out),
    .data_out_en(data_out_en),
    .ctrl_word(cw_link),
    .ctrl_tgl(ctgl_link),
    .read_busy(rbusy_link)
  );

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  // [RL26] start synchronised
  always_ff @(posedge sys_clk) begin
    cs_q <= {cs_q[1:0], convert_start_n};
    ctgl_q <= {ctgl_q[1:0], ctgl_link};
    rbusy_q <= {rbusy_q[0], rbusy_link};
  end
  assign cs_fall = cs_q[2] && !cs_q[1];
  assign cs_rise = !cs_q[2] && cs_q[1];

  // control word is stable for many cycles after its toggle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      // [RL8] start powered down
      ctrl_q <= acp_pkg::CTRL_RESET;
    end else if (ctgl_q[2] != ctgl_q[1]) begin
      ctrl_q <= cw_link;
    end
  end

  // [RL1] field selects power
  // [RL15] layout of 6040 word
  assign pf = {ctrl_q[acp_pkg::PF_HI_BIT], ctrl_q[acp_pkg::PF_LO_BIT]};

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q <= acp_pkg::ACP_OFF;
      cnt_q <= 16'h0000;
      start_pend_q <= 1'b0;
    end else begin
      case (st_q)
        acp_pkg::ACP_OFF: begin
          start_pend_q <= 1'b0;
          if (pf == acp_pkg::PF_UP) begin
            st_q <= acp_pkg::ACP_WAKE;
            cnt_q <= 16'h0000;
          end else if (pf != acp_pkg::PF_DOWN && cs_rise) begin
            // [RL5] rising edge wakes
            st_q <= acp_pkg::ACP_WAKE;
            cnt_q <= 16'h0000;
          end
        end
        acp_pkg::ACP_WAKE: begin
          cnt_q <= cnt_q + 16'h0001;
          // [RL25] early start remembered
          if (cs_fall) begin
            start_pend_q <= 1'b1;
          end
          if (pf == acp_pkg::PF_DOWN) begin
            st_q <= acp_pkg::ACP_OFF;
          // [RL7] one microsecond
          end else if (cnt_q >= 16'(PWRUP_CYC - 1)) begin
            cnt_q <= 16'h0000;
            if (start_pend_q || cs_fall) begin
              st_q <= acp_pkg::ACP_CONV;
            end else begin
              st_q <= acp_pkg::ACP_IDLE;
            end
            start_pend_q <= 1'b0;
          end
        end
        acp_pkg::ACP_IDLE: begin
          if (pf == acp_pkg::PF_DOWN) begin
            st_q <= acp_pkg::ACP_OFF;
          end else if (cs_fall) begin
            // [RL16] hold and convert
            st_q <= acp_pkg::ACP_CONV;
            cnt_q <= 16'h0000;
          end
        end
        acp_pkg::ACP_CONV: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q >= 16'(CONV_CYC - 1)) begin
            st_q <= acp_pkg::ACP_LOAD;
          end
        end
        acp_pkg::ACP_LOAD: begin
          // [RL17] load then evaluate
          // [RL4] start level decides
          if (pf == acp_pkg::PF_DOWN) begin
            st_q <= acp_pkg::ACP_OFF;
          end else if (!cs_q[2] && pf != acp_pkg::PF_UP) begin
            // [RL2] [RL3] automatic power-down
            st_q <= acp_pkg::ACP_OFF;
          end else begin
            st_q <= acp_pkg::ACP_IDLE;
          end
        end
        default: begin
          st_q <= acp_pkg::ACP_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result latch
  // ----------------------------------------------------------------
  // the link reads result_q live, so it only changes outside reads
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      result_q <= 16'h0000;
      pend_q <= 16'h0000;
      pend_valid_q <= 1'b0;
      result_ready <= 1'b0;
    end else begin
      result_ready <= 1'b0;
      if (st_q == acp_pkg::ACP_LOAD) begin
        // [RL13] left aligned
        pend_q <= {sar_result, 6'h00};
        pend_valid_q <= 1'b1;
      end else if (pend_valid_q && !rbusy_q[1]) begin
        // [RL19] deferred past read
        // [RL18] earlier read saw old word
        result_q <= pend_q;
        pend_valid_q <= 1'b0;
        result_ready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // power outputs
  // ----------------------------------------------------------------
  always_comb begin
    pwr.analog_on = st_q != acp_pkg::ACP_OFF;
    // [RL6] reference kept in partial
    // [RL10] reference up, no cap
    pwr.ref_on = pwr.analog_on || (pf == acp_pkg::PF_PARTIAL);
    pwr.tracking = st_q == acp_pkg::ACP_IDLE;
    pwr.converting = st_q == acp_pkg::ACP_CONV;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      analog_on <= 1'b0;
      ref_on <= 1'b0;
      tracking <= 1'b0;
      converting <= 1'b0;
      ext_ref <= 1'b0;
      power_field_high <= 1'b0;
      power_field_low <= 1'b0;
    end else begin
      analog_on <= pwr.analog_on;
      ref_on <= pwr.ref_on && !ctrl_q[acp_pkg::XREF_BIT];
      tracking <= pwr.tracking;
      converting <= pwr.converting;
      ext_ref <= ctrl_q[acp_pkg::XREF_BIT];
      power_field_high <= pf[1];
      power_field_low <= pf[0];
    end
  end
endmodule // acp_ctrl

// file: design/acp_pkg.sv
// Purpose: shared constants and types for the converter power control
// Assumes: sys_clk at 125 MHz, serial clock from the controller
// Notes: no software registers; control word arrives on the serial port
//
// Overview of operation
// [RL1] power field 11 up, 00 down
// [RL2] field 01: partial down if start low
// [RL3] field 10: full down if start low
// [RL4] start level at conversion end picks mode
// [RL5] start rising edge powers device back up
// [RL6] partial down keeps reference powered
// [RL7] power-up done within one microsecond
// [RL8] starts powered down until control write
// [RL9] controller waits reference start-up time
// [RL10] ready 30 us after supply, partial mode
// [RL11] msb first, 16-bit or two 8-bit
// [RL12] controller discards first exchange data
// [RL13] result left aligned straight binary
// [RL14] controller waits 1 us after power-up write
// [RL15] example words 6040 then 4040
// [RL16] start falling edge holds, converts 2.3 us
// [RL17] load result, then evaluate start level
// [RL18] early read returns previous result
// [RL19] defer load until running read ends
// [RL20] controller ends read 100 ns early
// [RL21] output enabled first clock after frame
// [RL22] controller reads after conversion time
// [RL23] control word applied on 13th edge
// [RL24] output released on 11th edge
// [RL25] early start times out power-up first
// [RL26] start input synchronised before use
package acp_pkg;
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int PWRUP_NS = 1000;
  localparam int CONV_NS = 2300;
  localparam int REF_UP_US = 30;
  localparam int PWRUP_CYC = (PWRUP_NS * CLK_MHZ) / 1000;
  localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int REF_UP_CYC = REF_UP_US * CLK_MHZ;
  // --------------------------------------------------------------
  // serial word layout
  // --------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int RES_W = 10;
  localparam int WR_EDGE = 13;
  localparam int RD_EDGE = 11;
  localparam int PF_HI_BIT = 14;
  localparam int PF_LO_BIT = 13;
  localparam int XREF_BIT = 6;
  localparam logic [1:0] PF_UP = 2'h3;
  localparam logic [1:0] PF_DOWN = 2'h0;
  localparam logic [1:0] PF_PARTIAL = 2'h1;
  localparam logic [1:0] PF_FULL = 2'h2;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ACP_OFF = 3'h0,
    ACP_WAKE = 3'h1,
    ACP_IDLE = 3'h3,
    ACP_CONV = 3'h2,
    ACP_LOAD = 3'h6
  } acp_state_t;

  typedef struct packed {
    logic analog_on;
    logic ref_on;
    logic tracking;
    logic converting;
  } acp_pwr_t;
endpackage

// file: design/acp_serial.sv
// Purpose: serial shift port on the link clock
// Assumes: frame syncs arrive on the link clock, are sampled there
// Notes: control word handed to sys_clk side by toggle handshake; result word read live
`timescale 1ns/10ps
module acp_serial (
  input wire logic link_clk,
  input wire logic resetn,
  input wire logic read_frame_sync,
  input wire logic write_frame_sync,
  input wire logic data_in,
  input wire logic [15:0] result_word,
  output logic data_out,
  output logic data_out_en,
  output logic [15:0] ctrl_word,
  output logic ctrl_tgl,
  output logic read_busy
);
  logic [2:0] rfs_q;
  logic [2:0] tfs_q;
  logic [1:0] rst_q;
  logic [4:0] rcnt_q;
  logic [4:0] wcnt_q;
  logic [15:0] rsh_q;
  logic [15:0] wsh_q;
  logic rd_act_q;
  logic wr_act_q;
  logic din_q;

  // ----------------------------------------------------------------
  // frame sync edges
  // ----------------------------------------------------------------
  // reset taken across; link clock only runs in frames
  always_ff @(posedge link_clk) begin
    rst_q <= {rst_q[0], resetn};
    rfs_q <= {rfs_q[1:0], read_frame_sync};
    tfs_q <= {tfs_q[1:0], write_frame_sync};
  end

  // ----------------------------------------------------------------
  // read side
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (!rst_q[1]) begin
      rd_act_q <= 1'b0;
      rcnt_q <= 5'h00;
      rsh_q <= 16'h0000;
      data_out <= 1'b0;
      data_out_en <= 1'b0;
    end else if (rfs_q[1] && !rfs_q[2]) begin
      // [RL21] enable after frame
      rd_act_q <= 1'b1;
      rcnt_q <= 5'h01;
      // [RL11] msb first out
      data_out <= result_word[15];
      rsh_q <= {result_word[14:0], 1'b0};
      data_out_en <= 1'b1;
    end else if (rd_act_q) begin
      rcnt_q <= rcnt_q + 5'h01;
      data_out <= rsh_q[15];
      rsh_q <= {rsh_q[14:0], 1'b0};
      // [RL24] release on 11th
      if (rcnt_q == 5'(acp_pkg::RD_EDGE - 1)) begin
        data_out_en <= 1'b0;
        rd_act_q <= 1'b0;
      end
    end
  end
  assign read_busy = rd_act_q;

  // ----------------------------------------------------------------
  // write side
  // ----------------------------------------------------------------
  always_ff @(negedge link_clk) begin
    din_q <= data_in;
  end

  always_ff @(posedge link_clk) begin
    if (!rst_q[1]) begin
      wr_act_q <= 1'b0;
      wcnt_q <= 5'h00;
      wsh_q <= 16'h0000;
      ctrl_word <= acp_pkg::CTRL_RESET;
      ctrl_tgl <= 1'b0;
    end else if (!tfs_q[1] && tfs_q[2]) begin
      wr_act_q <= 1'b1;
      wcnt_q <= 5'h00;
    end else if (wr_act_q) begin
      wcnt_q <= wcnt_q + 5'h01;
      wsh_q <= {wsh_q[14:0], din_q};
      // [RL23] apply on 13th
      if (wcnt_q == 5'(acp_pkg::WR_EDGE - 1)) begin
        ctrl_word <= {wsh_q[11:0], din_q, 3'h0};
        ctrl_tgl <= ~ctrl_tgl;
        wr_act_q <= 1'b0;
      end
    end
  end
endmodule // acp_serial

// file: bench/acp_ctrl_asserts.sv
// Purpose: port-level checks of power mode and conversion sequencing
// Assumes: sized for the bench's short power-up and conversion counts
// Notes: windows allow for the three-flop start synchroniser
`timescale 1ns/10ps
module acp_ctrl_asserts #(
  parameter int PWRUP_CYC = 4,
  parameter int CONV_CYC = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic convert_start_n,
  input wire logic read_frame_sync,
  input wire logic write_frame_sync,
  input wire logic data_in,
  input wire logic [9:0] sar_result,
  input wire logic data_out,
  input wire logic data_out_en,
  input wire logic power_field_high,
  input wire logic power_field_low,
  input wire logic analog_on,
  input wire logic ref_on,
  input wire logic tracking,
  input wire logic converting,
  input wire logic ext_ref,
  input wire logic result_ready
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic [1:0] pf;
  int conv_len_q;
  assign pf = {power_field_high, power_field_low};
  always_ff @(posedge sys_clk) begin
    if (!resetn || !converting) conv_len_q <= 0;
    else conv_len_q <= conv_len_q + 1;
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_conv_len;
    @(posedge sys_clk) disable iff (!resetn) $fell(converting) |->
      conv_len_q >= CONV_CYC && conv_len_q <= CONV_CYC + 2;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("bad conv length");
  property p_hold;
    @(posedge sys_clk) disable iff (!resetn)
      converting |-> !tracking && analog_on;
  endproperty
  a_hold: assert property (p_hold) else $error("convert unpowered");
  property p_start;
    @(posedge sys_clk) disable iff (!resetn) $fell(convert_start_n) &&
      analog_on && !converting |-> ##[2:12] converting;
  endproperty
  a_start: assert property (p_start) else $error("no conversion");
  property p_partial;
    @(posedge sys_clk) disable iff (!resetn) $fell(converting) &&
      pf == acp_pkg::PF_PARTIAL && !convert_start_n |->
      ##[1:6] ((ref_on == !ext_ref) && !analog_on);
  endproperty
  a_partial: assert property (p_partial) else $error("partial down");
  property p_full;
    @(posedge sys_clk) disable iff (!resetn) $fell(converting) &&
      pf == acp_pkg::PF_FULL && !convert_start_n |->
      ##[1:6] (!ref_on && !analog_on);
  endproperty
  a_full: assert property (p_full) else $error("full down");
  property p_stay;
    @(posedge sys_clk) disable iff (!resetn) $fell(converting) &&
      convert_start_n && pf != acp_pkg::PF_DOWN |-> ##1 analog_on[*4];
  endproperty
  a_stay: assert property (p_stay) else $error("powered down");
  property p_wake;
    @(posedge sys_clk) disable iff (!resetn) $rose(convert_start_n) &&
      !analog_on && (pf == acp_pkg::PF_PARTIAL || pf == acp_pkg::PF_FULL)
      |-> ##[1:10] analog_on;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_down;
    @(posedge sys_clk) disable iff (!resetn) pf == acp_pkg::PF_DOWN &&
      $past(pf, 3) == acp_pkg::PF_DOWN |-> !analog_on && !ref_on;
  endproperty
  a_down: assert property (p_down) else $error("not down");
  property p_release;
    @(posedge link_clk) disable iff (!resetn) $rose(data_out_en) |->
      data_out_en[*8] ##[1:3] !data_out_en;
  endproperty
  a_release: assert property (p_release) else $error("out enable");
  c_partial: cover property (@(posedge sys_clk) $fell(converting) && pf == 2'h1);
  c_full: cover property (@(posedge sys_clk) $fell(converting) && pf == 2'h2);
  c_read: cover property (@(posedge link_clk) $rose(data_out_en));
endmodule // acp_ctrl_asserts

bind acp_ctrl acp_ctrl_asserts #(.PWRUP_CYC(PWRUP_CYC), .CONV_CYC(CONV_CYC))
  u_chk (.sys_clk(sys_clk), .resetn(resetn), .link_clk(link_clk),
  .convert_start_n(convert_start_n), .read_frame_sync(read_frame_sync),
  .write_frame_sync(write_frame_sync), .data_in(data_in),
  .sar_result(sar_result), .data_out(data_out), .data_out_en(data_out_en),
  .power_field_high(power_field_high), .power_field_low(power_field_low),
  .analog_on(analog_on), .ref_on(ref_on), .tracking(tracking),
  .converting(converting), .ext_ref(ext_ref), .result_ready(result_ready));

// file: bench/acp_host.sv
// Purpose: serial master model, full duplex 16-bit frames
// Assumes: link clock runs only around frames, 32 ns period
// Notes: data_in toggles each clock outside the data bits and rests at its last bit between frames
`timescale 1ns/10ps
module acp_host (
  output logic link_clk,
  output logic read_frame_sync,
  output logic write_frame_sync,
  output logic data_in,
  input wire logic data_out,
  input wire logic data_out_en,
  output logic [15:0] rx_word,
  output logic rx_valid
);
  initial begin
    link_clk = 1'b0;
    read_frame_sync = 1'b0;
    write_frame_sync = 1'b1;
    data_in = 1'b0;
    rx_word = 16'h0000;
    rx_valid = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) begin
      #16 link_clk = 1'b1;
      #16 link_clk = 1'b0;
    end
  endtask
  task automatic xfer(input logic [15:0] w);
    int n;
    logic [15:0] rd;
    n = 0;
    rd = 16'h0000;
    #7;
    read_frame_sync = 1'b1;
    write_frame_sync = 1'b0;
    // msb on the third clock: frame sync is seen through two flops
    for (int e = 1; e <= 20; e++) begin
      #16 link_clk = 1'b1;
      if (e >= 3 && e <= 18) data_in = w[18-e];
      else data_in = ~data_in;
      #16 link_clk = 1'b0;
      if (data_out_en === 1'b1) begin
        rd = {rd[14:0], data_out};
        n++;
      end
    end
    read_frame_sync = 1'b0;
    write_frame_sync = 1'b1;
    // trailing clocks let the frame syncs be seen idle
    tick(3);
    rx_word = rd << (16 - n);
    rx_valid = 1'b1;
    #5 rx_valid = 1'b0;
  endtask
endmodule // acp_host

// file: bench/acp_ctrl_test.sv
// Purpose: mode, wake, deferral and power-field scenarios
// Assumes: short power-up and conversion counts for a fast run
// Notes: read words queued by the driver, checked on arrival
`timescale 1ns/10ps
module acp_ctrl_test;
  logic sys_clk, resetn, convert_start_n, link_clk, read_frame_sync;
  logic write_frame_sync, data_in, data_out, data_out_en, ext_ref;
  logic power_field_high, power_field_low, analog_on, ref_on;
  logic tracking, converting, result_ready, rx_valid, an, rf;
  logic [9:0] sar_result, prev;
  logic [15:0] rx_word;
  logic [31:0] lfsr;
  logic [15:0] exp_q[$];
  logic [1:0] fld [5] = '{2'h3, 2'h1, 2'h1, 2'h2, 2'h2};
  logic lvl [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  int fails, n_tests, i;
  wire [15:0] pwr_w = {11'h0, ext_ref, power_field_high, power_field_low,
    analog_on, ref_on};
  acp_ctrl #(.PWRUP_CYC(4), .CONV_CYC(8)) DUT (.sys_clk(sys_clk),
    .resetn(resetn), .link_clk(link_clk), .convert_start_n(convert_start_n),
    .read_frame_sync(read_frame_sync), .write_frame_sync(write_frame_sync),
    .data_in(data_in), .sar_result(sar_result), .data_out(data_out),
    .data_out_en(data_out_en), .power_field_high(power_field_high),
    .power_field_low(power_field_low), .analog_on(analog_on),
    .ref_on(ref_on), .tracking(tracking), .converting(converting),
    .ext_ref(ext_ref), .result_ready(result_ready));
  acp_host u_host (.link_clk(link_clk), .read_frame_sync(read_frame_sync),
    .write_frame_sync(write_frame_sync), .data_in(data_in),
    .data_out(data_out), .data_out_en(data_out_en), .rx_word(rx_word),
    .rx_valid(rx_valid));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
    input string what);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic xw(input logic [15:0] w);
    exp_q.push_back({prev, 6'h0});
    u_host.xfer(w);
  endtask
  task automatic conv(input logic end_lvl);
    int k;
    @(negedge sys_clk);
    convert_start_n = 1'b0;
    lfsr = lfsr_next(lfsr);
    sar_result = lfsr[9:0];
    cyc(3);
    if (end_lvl) convert_start_n = 1'b1;
    for (k = 0; k < 400 && result_ready !== 1'b1; k++) @(negedge sys_clk);
    if (k == 400) begin
      fails++;
      finish_test();
    end
    prev = sar_result;
  endtask
  // ------------------------------------------------------------
  // read word monitor
  // ------------------------------------------------------------
  always @(posedge rx_valid) begin
    if (exp_q.size() > 0)
      check({rx_word[15:6], 6'h0}, exp_q.pop_front(), "read word");
  end
  initial begin
    resetn = 1'b0;
    convert_start_n = 1'b1;
    sar_result = 10'h000;
    lfsr = 32'h828d06f9;
    prev = 10'h000;
    fails = 0;
    n_tests = 0;
    cyc(5);
    // link side reset needs its own edges
    u_host.tick(5);
    @(negedge sys_clk);
    resetn = 1'b1;
    u_host.tick(5);
    check(pwr_w, 16'h0000, "power at start");
    u_host.xfer(16'h6040);
    cyc(130);
    check(pwr_w, 16'h001e, "power after setup");
    for (i = 0; i < 5; i++) begin
      xw({1'b0, fld[i], 6'h0, 1'b0, 6'h0});
      conv(lvl[i]);
      cyc(8);
      an = lvl[i] | (fld[i] == 2'h3);
      rf = an | (fld[i] == 2'h1);
      check(pwr_w, {11'h0, 1'b0, fld[i], an, rf}, "mode power");
      @(negedge sys_clk);
      convert_start_n = 1'b1;
      conv(1'b1);
      cyc(4);
      check(pwr_w, {11'h0, 1'b0, fld[i], 2'h3}, "wake power");
      $display("mode test %0d done", i);
    end
    // read starts early enough to be busy at conversion end
    fork
      begin
        conv(1'b1);
        check({15'h0, data_out_en}, 16'h0000, "load after read");
      end
      xw(16'h4040);
    join
    xw(16'h4040);
    check(pwr_w, 16'h001a, "field ten");
    $display("deferred read test done");
    xw(16'h0040);
    cyc(10);
    check(pwr_w, 16'h0010, "down power");
    $display("power down test done");
    finish_test();
  end
endmodule // acp_ctrl_test
